// ==== rtl/pvi_ctrl.sv ====
/*
  Sixteen-channel prioritized, vectored interrupt controller with an
  eight-line edge-detecting interrupt/I-O port and asynchronous host bus.
  Assumes: host strobes, pins and source requests are asynchronous to
  clk_in and are held for several clock periods; the three-state data
  bus and open-drain request line are resolved outside.
*/
// Behaviour
// (RL1) read only while chip enable and read strobe both active; bus else released
// (RL2) write needs enable and write strobe; data latched after either deasserts
// (RL3) host must include io_request_n in chip-enable decoding
// (RL4) disabled channel ignores events, loses pending, keeps in-service; enables readable
// (RL5) event on enabled channel sets pending; passing vector clears it
// (RL6) pending readable; writing zero clears a bit, one leaves it
// (RL7) cleared mask keeps latching pending but stops request; setting it resumes
// (RL8) no request: irq inactive, priority_out high; priority_in low blocks both
// (RL9) one pointer_vector bit picks software or automatic end of interrupt
// (RL10) automatic mode: vector passing only clears pending, no in-service kept
// (RL11) software mode: vector sets in-service; lower channels cannot request
// (RL12) in-service readable; zero clears bit, one leaves it, never set
// (RL13) return_from_irq detected clears the active in-service bit
// (RL14) second event while in service latches pending, requests after clearing
// (RL15) vector is base bits 7:5, channel code bits 4:1, bit 0 zero
// (RL16) fetch low freezes priority; with io_request_n low vector is driven
// (RL17) codes 15..8: pin7, pin6, timer A, rx full, rx err, tx empty, tx err, timer B
// (RL18) codes 7..0: pin5, pin4, timer C, timer D, pin3, pin2, pin1, pin0
// (RL19) group A registers hold codes 15..8, group B codes 7..0
// (RL20) edge bit xor pin feeds falling detector; changing it may interrupt
// (RL21) direction zero makes pin an input, one a push-pull output
// (RL22) port read gives latch for outputs, live pin for inputs
// (RL23) pointer low three bits select the register behind indirect_data
// (RL24) fetch plus read strobe watched for the two-byte return opcode
// (RL25) reset clears control, disables channels, clears pending, pins to input
// (RL26) pins and source pulses are synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
module pvi_ctrl
  import pvi_pkg::*;
#(
  parameter int NPIN = PVI_NPIN
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire pvi_host_s host_in,
  output logic [7:0] dbus_out,
  output logic dbus_oe_n_out,
  output logic irq_out,
  output logic irq_oe_n_out,
  input wire logic priority_in,
  output logic priority_out,
  input wire logic [NPIN-1:0] gpio_in,
  output logic [NPIN-1:0] gpio_out,
  output logic [NPIN-1:0] gpio_oe_n_out,
  input wire pvi_src_s src_in
);

  if (NPIN != PVI_NPIN) begin : g_bad_npin
    $error("pvi_ctrl: NPIN must equal eight");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  pvi_host_s host_m_ff, host_s_ff;
  logic [NPIN-1:0] pin_m_ff, pin_s_ff;
  pvi_src_s src_m_ff, src_s_ff;
  logic prio_m_ff, prio_s_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      host_m_ff <= '1;
      host_s_ff <= '1;
      pin_m_ff <= '0;
      pin_s_ff <= '0;
      src_m_ff <= '0;
      src_s_ff <= '0;
      prio_m_ff <= 1'b0;
      prio_s_ff <= 1'b0;
    end else begin
      host_m_ff <= host_in;
      host_s_ff <= host_m_ff; // [RL26]
      pin_m_ff <= gpio_in;
      pin_s_ff <= pin_m_ff; // [RL26]
      src_m_ff <= src_in;
      src_s_ff <= src_m_ff; // [RL26]
      prio_m_ff <= priority_in;
      prio_s_ff <= prio_m_ff;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] en_ff, pend_ff, mask_ff, isr_ff;
  logic [7:0] edge_ff, dir_ff, port_ff, pv_ff;
  logic [15:0] nxt_en, nxt_pend, nxt_isr;

  // ****************************************
  // host strobes
  // ****************************************
  logic rd_act, wr_act, wr_prev_ff, wr_commit;
  logic [3:0] waddr_ff;
  logic [7:0] wdata_ff;

  assign rd_act = !host_s_ff.cs_n && !host_s_ff.rd_n; // [RL1]
  assign wr_act = !host_s_ff.cs_n && !host_s_ff.wr_n; // [RL2]
  assign wr_commit = wr_prev_ff && !wr_act; // [RL2]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_prev_ff <= 1'b0;
      waddr_ff <= 4'h0;
      wdata_ff <= PVI_RST8;
    end else begin
      wr_prev_ff <= wr_act;
      if (wr_act) begin
        waddr_ff <= host_s_ff.addr;
        wdata_ff <= host_s_ff.data;
      end
    end
  end

  logic [2:0] ptr;
  logic w_ind, w_port, w_pv;
  logic [15:0] pend_wclr, isr_wclr, en_wr;
  assign ptr = pv_ff[2:0]; // [RL23]
  assign w_ind = wr_commit && (waddr_ff == PVI_A_IND);
  assign w_port = wr_commit && (waddr_ff == PVI_A_PORT);
  assign w_pv = wr_commit && (waddr_ff == PVI_A_PV);

  always_comb begin
    pend_wclr = '0;
    isr_wclr = '0;
    en_wr = en_ff;
    if (wr_commit) begin
      case (waddr_ff)
        PVI_A_PEND_B: pend_wclr[7:0] = ~wdata_ff; // [RL6]
        PVI_A_PEND_A: pend_wclr[15:8] = ~wdata_ff; // [RL6] [RL19]
        PVI_A_ISR_B: isr_wclr[7:0] = ~wdata_ff; // [RL12]
        PVI_A_ISR_A: isr_wclr[15:8] = ~wdata_ff; // [RL12]
        default: isr_wclr = '0;
      endcase
    end
    if (w_ind && ptr == PVI_I_EN_B) begin
      en_wr[7:0] = wdata_ff;
    end
    if (w_ind && ptr == PVI_I_EN_A) begin
      en_wr[15:8] = wdata_ff;
    end
    nxt_en = en_wr;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_ff <= PVI_RST16; // [RL25]
      mask_ff <= PVI_RST16;
      edge_ff <= PVI_RST8;
      dir_ff <= PVI_RST8; // [RL25]
      port_ff <= PVI_RST8;
      pv_ff <= PVI_RST8;
    end else begin
      en_ff <= nxt_en; // [RL4]
      if (wr_commit && waddr_ff == PVI_A_MASK_B) mask_ff[7:0] <= wdata_ff; // [RL7]
      if (wr_commit && waddr_ff == PVI_A_MASK_A) mask_ff[15:8] <= wdata_ff; // [RL7]
      if (w_pv) pv_ff <= wdata_ff; // [RL9]
      if (w_port) port_ff <= wdata_ff; // [RL22]
      if (w_ind && ptr == PVI_I_EDGE) edge_ff <= wdata_ff; // [RL20]
      if (w_ind && ptr == PVI_I_DIR) dir_ff <= wdata_ff; // [RL21]
    end
  end

  // ****************************************
  // event sources
  // ****************************************
  logic [NPIN-1:0] cmp_now, cmp_prev_ff, pin_ev;
  pvi_src_s src_prev_ff;
  logic [7:0] src_ev;
  logic [15:0] ev;

  assign cmp_now = pin_s_ff ^ edge_ff; // [RL20]
  assign pin_ev = cmp_prev_ff & ~cmp_now; // [RL20]
  assign src_ev = src_s_ff & ~src_prev_ff; // [RL26]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_prev_ff <= '0;
      src_prev_ff <= '0;
    end else begin
      cmp_prev_ff <= cmp_now;
      src_prev_ff <= src_s_ff;
    end
  end

  always_comb begin
    ev = '0;
    ev[15:14] = pin_ev[7:6]; // [RL17]
    ev[PVI_CH_TMR_A] = src_ev[7];
    ev[PVI_CH_RX_FULL] = src_ev[6];
    ev[PVI_CH_RX_ERR] = src_ev[5];
    ev[PVI_CH_TX_EMPTY] = src_ev[4];
    ev[PVI_CH_TX_ERR] = src_ev[3];
    ev[PVI_CH_TMR_B] = src_ev[2];
    ev[7:6] = pin_ev[5:4]; // [RL18]
    ev[PVI_CH_TMR_C] = src_ev[1];
    ev[PVI_CH_TMR_D] = src_ev[0];
    ev[3:0] = pin_ev[3:0]; // [RL18]
  end

  // ****************************************
  // priority resolution and freeze
  // ****************************************
  logic [15:0] allowed, req;
  logic req_any;
  logic [3:0] win;
  logic frz_valid_ff;
  logic [3:0] frz_code_ff;
  logic fetch_low;

  assign fetch_low = !host_s_ff.fetch_n;

  for (genvar i = 0; i < PVI_NCH; i++) begin : g_allow
    assign allowed[i] = ~|isr_ff[PVI_NCH-1:i]; // [RL11] [RL14]
  end
  assign req = pend_ff & mask_ff & en_ff & allowed; // [RL7]
  assign req_any = |req;

  always_comb begin
    win = 4'h0;
    for (int k = 0; k < PVI_NCH; k++) begin
      if (req[k]) win = 4'(k);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frz_valid_ff <= 1'b0;
      frz_code_ff <= 4'h0;
    end else if (!fetch_low) begin
      frz_valid_ff <= req_any; // [RL16]
      frz_code_ff <= win;
    end
  end

  // ****************************************
  // acknowledge and vector
  // ****************************************
  logic ack_act, ack_prev_ff, ack_start, ack_ours, ack_ours_ff;
  logic [7:0] vec_ff;
  logic [15:0] ack_onehot;

  assign ack_act = fetch_low && !host_s_ff.io_request_n; // [RL16]
  assign ack_start = ack_act && !ack_prev_ff;
  assign ack_ours = ack_start && prio_s_ff && frz_valid_ff;
  assign ack_onehot = ack_ours ? (16'h0001 << frz_code_ff) : 16'h0000;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_prev_ff <= 1'b0;
      ack_ours_ff <= 1'b0;
      vec_ff <= PVI_RST8;
    end else begin
      ack_prev_ff <= ack_act;
      if (ack_ours) begin
        ack_ours_ff <= 1'b1;
        vec_ff <= {pv_ff[7:PVI_PV_BASE_LSB], frz_code_ff, 1'b0}; // [RL15]
      end else if (!ack_act) begin
        ack_ours_ff <= 1'b0; // [RL16]
      end
    end
  end

  // ****************************************
  // return-from-interrupt watcher
  // ****************************************
  pvi_ret_e ret_st_ff;
  logic fetch_rd, fetch_rd_prev_ff, fetch_end, ret_pulse;
  logic [7:0] op_ff;
  logic [15:0] ret_clr;

  assign fetch_rd = fetch_low && !host_s_ff.rd_n; // [RL24]
  assign fetch_end = fetch_rd_prev_ff && !fetch_rd;
  assign ret_pulse = fetch_end && ret_st_ff == PVI_RS_PREFIX && op_ff == PVI_OP_RETURN;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_rd_prev_ff <= 1'b0;
      op_ff <= PVI_RST8;
      ret_st_ff <= PVI_RS_IDLE;
    end else begin
      fetch_rd_prev_ff <= fetch_rd;
      if (fetch_rd) op_ff <= host_s_ff.data;
      if (fetch_end) begin
        case (ret_st_ff)
          PVI_RS_IDLE: ret_st_ff <= (op_ff == PVI_OP_PREFIX) ? PVI_RS_PREFIX : PVI_RS_IDLE;
          PVI_RS_PREFIX: ret_st_ff <= (op_ff == PVI_OP_PREFIX) ? PVI_RS_PREFIX : PVI_RS_IDLE;
          default: ret_st_ff <= PVI_RS_IDLE;
        endcase
      end
    end
  end

  // highest in-service bit is the one being returned from
  always_comb begin
    ret_clr = '0;
    for (int k = 0; k < PVI_NCH; k++) begin
      if (isr_ff[k]) ret_clr = 16'h0001 << k;
    end
    if (!ret_pulse) ret_clr = '0; // [RL13]
  end

  // ****************************************
  // pending and in-service state
  // ****************************************
  logic soft_eoi;
  assign soft_eoi = pv_ff[PVI_PV_SOFT_BIT]; // [RL9]

  always_comb begin
    // new events win over a write or acknowledge clear in the same cycle; disabling the channel wins over events
    nxt_pend = ((pend_ff & ~pend_wclr & ~ack_onehot) | ev) & nxt_en; // [RL4] [RL5] [RL6] [RL14]
    nxt_isr = isr_ff & ~isr_wclr & ~ret_clr; // [RL12] [RL13]
    if (soft_eoi) nxt_isr = nxt_isr | ack_onehot; // [RL10] [RL11]
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_ff <= PVI_RST16; // [RL25]
      isr_ff <= PVI_RST16;
    end else begin
      pend_ff <= nxt_pend;
      isr_ff <= nxt_isr;
    end
  end

  // ****************************************
  // read data and pin outputs
  // ****************************************
  logic [7:0] rd_mux, ind_mux, port_rd;
  logic [7:0] dbus_ff;
  logic dbus_oe_n_ff, irq_oe_n_ff, prio_out_ff, req_eff;

  assign port_rd = (port_ff & dir_ff) | (pin_s_ff & ~dir_ff); // [RL22]

  always_comb begin
    case (ptr)
      PVI_I_EDGE: ind_mux = edge_ff;
      PVI_I_EN_B: ind_mux = en_ff[7:0]; // [RL4]
      PVI_I_EN_A: ind_mux = en_ff[15:8];
      PVI_I_DIR: ind_mux = dir_ff;
      default: ind_mux = PVI_RST8;
    endcase
    case (host_s_ff.addr)
      PVI_A_IND: rd_mux = ind_mux; // [RL23]
      PVI_A_PORT: rd_mux = port_rd;
      PVI_A_PEND_B: rd_mux = pend_ff[7:0];
      PVI_A_PEND_A: rd_mux = pend_ff[15:8];
      PVI_A_ISR_B: rd_mux = isr_ff[7:0];
      PVI_A_ISR_A: rd_mux = isr_ff[15:8];
      PVI_A_MASK_B: rd_mux = mask_ff[7:0];
      PVI_A_MASK_A: rd_mux = mask_ff[15:8];
      PVI_A_PV: rd_mux = pv_ff;
      default: rd_mux = PVI_RST8;
    endcase
  end

  assign req_eff = fetch_low ? frz_valid_ff : req_any; // [RL16]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dbus_ff <= PVI_RST8;
      dbus_oe_n_ff <= 1'b1;
      irq_oe_n_ff <= 1'b1;
      prio_out_ff <= 1'b0;
    end else begin
      dbus_ff <= rd_act ? rd_mux : vec_ff;
      dbus_oe_n_ff <= !(rd_act || (ack_ours_ff && ack_act)); // [RL1] [RL16]
      irq_oe_n_ff <= !(prio_s_ff && req_eff); // [RL8]
      prio_out_ff <= prio_s_ff && !req_eff; // [RL8]
    end
  end

  assign dbus_out = dbus_ff;
  assign dbus_oe_n_out = dbus_oe_n_ff;
  assign irq_out = 1'b0;
  assign irq_oe_n_out = irq_oe_n_ff;
  assign priority_out = prio_out_ff;
  assign gpio_out = port_ff; // [RL21]
  assign gpio_oe_n_out = ~dir_ff; // [RL21]

  // ****************************************
  // assertions
  // ****************************************
  sequence s_ack_taken;
    ack_ours;
  endsequence

  // vector appears two edges after the acknowledge is taken
  sequence s_vec_shown;
    s_ack_taken ##2 !dbus_oe_n_out;
  endsequence

  a_read_drive: assert property (@(posedge clk_in) disable iff (rst_in) rd_act |=> !dbus_oe_n_out) // [RL1]
    else $error("read active but bus released");
  a_bus_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rd_act && !(ack_ours_ff && ack_act)) |=> dbus_oe_n_out) // [RL1]
    else $error("bus driven outside read or acknowledge");
  a_mask_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_commit && waddr_ff == PVI_A_MASK_B) |=> mask_ff[7:0] == $past(wdata_ff)) // [RL2]
    else $error("mask write not latched at strobe release");
  a_disabled_clear: assert property (@(posedge clk_in) disable iff (rst_in) (pend_ff & ~en_ff) == 16'h0000) // [RL4]
    else $error("pending set on disabled channel");
  a_event_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    |(ev & nxt_en) |=> (pend_ff & $past(ev & nxt_en)) == $past(ev & nxt_en)) // [RL5]
    else $error("event on enabled channel not latched");
  a_auto_no_isr: assert property (@(posedge clk_in) disable iff (rst_in)
    (ack_ours && !soft_eoi) |=> (isr_ff & ~$past(isr_ff)) == 16'h0000) // [RL10]
    else $error("in-service set in automatic mode");
  a_soft_isr: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_ack_taken ##0 soft_eoi) |=> isr_ff[$past(frz_code_ff)]) // [RL11]
    else $error("in-service not set in software mode");
  a_isr_no_set: assert property (@(posedge clk_in) disable iff (rst_in)
    !ack_ours |=> (isr_ff & ~$past(isr_ff)) == 16'h0000) // [RL12]
    else $error("in-service set without acknowledge");
  a_vector_form: assert property (@(posedge clk_in) disable iff (rst_in)
    s_vec_shown |-> dbus_out == {$past(pv_ff[7:PVI_PV_BASE_LSB], 2), $past(frz_code_ff, 2), 1'b0}) // [RL15]
    else $error("vector layout wrong");
  a_chain_block: assert property (@(posedge clk_in) disable iff (rst_in)
    !prio_s_ff |=> irq_oe_n_out && !priority_out) // [RL8]
    else $error("priority_in low did not block request");
  a_return_from_irq_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (ret_pulse && |isr_ff && !ack_ours) |=> $countones(isr_ff) < $countones($past(isr_ff))) // [RL13]
    else $error("return did not clear in-service");

endmodule // pvi_ctrl
`default_nettype wire

// ==== rtl/pvi_pkg.sv ====
/*
  Shared constants and types for the prioritized vectored interrupt
  controller with its eight-line interrupt/I-O port.
  Assumes a single 100 MHz logic clock; the host bus is asynchronous.
*/
package pvi_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int PVI_NCH = 16;
  localparam int PVI_NPIN = 8;
  localparam logic [7:0] PVI_RST8 = 8'h00;
  localparam logic [15:0] PVI_RST16 = 16'h0000;

  // ****************************************
  // direct register addresses
  // ****************************************
  localparam logic [3:0] PVI_A_IND = 4'h0;
  localparam logic [3:0] PVI_A_PORT = 4'h1;
  localparam logic [3:0] PVI_A_PEND_B = 4'h2;
  localparam logic [3:0] PVI_A_PEND_A = 4'h3;
  localparam logic [3:0] PVI_A_ISR_B = 4'h4;
  localparam logic [3:0] PVI_A_ISR_A = 4'h5;
  localparam logic [3:0] PVI_A_MASK_B = 4'h6;
  localparam logic [3:0] PVI_A_MASK_A = 4'h7;
  localparam logic [3:0] PVI_A_PV = 4'h8;

  // ****************************************
  // indirect register indices (pointer field)
  // ****************************************
  localparam logic [2:0] PVI_I_EDGE = 3'h3;
  localparam logic [2:0] PVI_I_EN_B = 3'h4;
  localparam logic [2:0] PVI_I_EN_A = 3'h5;
  localparam logic [2:0] PVI_I_DIR = 3'h6;

  // ****************************************
  // pointer/vector fields
  // ****************************************
  localparam int PVI_PV_SOFT_BIT = 3;
  localparam int PVI_PV_BASE_LSB = 5;

  // ****************************************
  // channel codes of internal sources
  // ****************************************
  localparam int PVI_CH_TMR_A = 13;
  localparam int PVI_CH_RX_FULL = 12;
  localparam int PVI_CH_RX_ERR = 11;
  localparam int PVI_CH_TX_EMPTY = 10;
  localparam int PVI_CH_TX_ERR = 9;
  localparam int PVI_CH_TMR_B = 8;
  localparam int PVI_CH_TMR_C = 5;
  localparam int PVI_CH_TMR_D = 4;

  // ****************************************
  // return-from-interrupt opcode bytes
  // ****************************************
  localparam logic [7:0] PVI_OP_PREFIX = 8'hed;
  localparam logic [7:0] PVI_OP_RETURN = 8'h4d;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic fetch_n;
    logic io_request_n;
    logic [3:0] addr;
    logic [7:0] data;
  } pvi_host_s;

  // internal request sources, one pulse or level each
  typedef struct packed {
    logic tmr_a;
    logic rx_full;
    logic rx_err;
    logic tx_empty;
    logic tx_err;
    logic tmr_b;
    logic tmr_c;
    logic tmr_d;
  } pvi_src_s;

  typedef enum logic {PVI_RS_IDLE = 1'b0, PVI_RS_PREFIX = 1'b1} pvi_ret_e;

endpackage

// ==== testbench/pvi_host_model.sv ====
/*
  Host processor bus model: register reads and writes, interrupt
  acknowledge and opcode fetches for return detection.
  Assumes one caller at a time; every task starts and ends at a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pvi_host_model
  import pvi_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] dbus_in,
  input wire logic dbus_oe_n_in,
  output pvi_host_s host_out
);
  // ****************************************
  // bus state and data wire resolution
  // ****************************************
  logic cs_n, rd_n, wr_n, fetch_n, io_request_n, drv;
  logic [3:0] addr;
  logic [7:0] hdata, idle_pat, bus;

  initial begin
    {cs_n, rd_n, wr_n, fetch_n, io_request_n} = 5'h1f;
    drv = 1'b0;
    addr = 4'h0;
    hdata = 8'h00;
    idle_pat = 8'h00;
  end

  // released bus shows a pattern that moves every cycle
  always @(posedge clk_in) idle_pat <= idle_pat + 8'h01;
  assign bus = drv ? hdata : (!dbus_oe_n_in ? dbus_in : idle_pat);
  assign host_out = {cs_n, rd_n, wr_n, fetch_n, io_request_n, addr, bus};

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    hdata = d;
    drv = 1'b1;
    @(negedge clk_in);
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(6);
    cs_n = 1'b1;
    wr_n = 1'b1;
    cyc(1);
    drv = 1'b0;
    cyc(5);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    @(negedge clk_in);
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(7);
    d = bus;
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(5);
  endtask

  task automatic ack(output logic oe_n, output logic [7:0] d);
    @(negedge clk_in);
    fetch_n = 1'b0;
    cyc(4);
    io_request_n = 1'b0;
    cyc(8);
    oe_n = dbus_oe_n_in;
    d = bus;
    fetch_n = 1'b1;
    io_request_n = 1'b1;
    cyc(6);
  endtask

  task automatic opf(input logic [7:0] d);
    @(negedge clk_in);
    hdata = d;
    drv = 1'b1;
    @(negedge clk_in);
    fetch_n = 1'b0;
    rd_n = 1'b0;
    cyc(6);
    fetch_n = 1'b1;
    rd_n = 1'b1;
    cyc(1);
    drv = 1'b0;
    cyc(5);
  endtask

  task automatic irq_return();
    opf(PVI_OP_PREFIX);
    opf(PVI_OP_RETURN);
  endtask
endmodule // pvi_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the interrupt controller.
  Assumes pvi_host_model drives the host bus; pins and sources come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pvi_pkg::*;
;
  logic clk_in, rst_in, priority_in, dbus_oe_n, irq, irq_oe_n, priority_out, oe;
  logic [7:0] dbus, gpio_out, gpio_oe_n, pin_drv, pv_ctl, v;
  wire logic [7:0] gpio_in;
  pvi_src_s src;
  pvi_host_s host;
  int fail_count, check_count;

  always #5 clk_in = ~clk_in;
  assign gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & pin_drv);

  pvi_ctrl #(.NPIN(8)) u_pvi_ctrl (.clk_in(clk_in), .rst_in(rst_in), .host_in(host), .dbus_out(dbus),
    .dbus_oe_n_out(dbus_oe_n), .irq_out(irq), .irq_oe_n_out(irq_oe_n), .priority_in(priority_in),
    .priority_out(priority_out), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n),
    .src_in(src));
  pvi_host_model u_pvi_host_model (.clk_in(clk_in), .dbus_in(dbus), .dbus_oe_n_in(dbus_oe_n),
    .host_out(host));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      fail_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic iwr(input logic [2:0] idx, input logic [7:0] d);
    u_pvi_host_model.wr(PVI_A_PV, {pv_ctl[7:3], idx});
    u_pvi_host_model.wr(PVI_A_IND, d);
  endtask

  task automatic ird(input logic [2:0] idx, output logic [7:0] d);
    u_pvi_host_model.wr(PVI_A_PV, {pv_ctl[7:3], idx});
    u_pvi_host_model.rd(PVI_A_IND, d);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    u_pvi_host_model.rd(a, v);
    chk("register", v, exp);
  endtask

  // one event on channel code c: pin falling edge or source pulse
  task automatic ev(input int c);
    int p;
    int s;
    p = (c == 15) ? 7 : (c == 14) ? 6 : (c == 7) ? 5 : (c == 6) ? 4 : (c < 4) ? c : -1;
    s = (c >= 8) ? c - 6 : c - 4;
    if (p >= 0) begin
      pin_drv[p] = 1'b0;
      cyc(4);
      pin_drv[p] = 1'b1;
    end else begin
      src[s] = 1'b1;
      cyc(4);
      src[s] = 1'b0;
    end
    cyc(8);
  endtask

  task automatic ackchk(input logic [3:0] c);
    u_pvi_host_model.ack(oe, v);
    chk("ack drive", {7'h0, oe}, 8'h00);
    chk("vector", v, {pv_ctl[7:5], c, 1'b0});
    chk("bus release", {7'h0, dbus_oe_n}, 8'h01);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("bus idle", {7'h0, dbus_oe_n}, 8'h01);
    chk("pin dir", gpio_oe_n, 8'hff);
    chk("irq level", {7'h0, irq}, 8'h00);
    chk("chain out", {7'h0, priority_out}, 8'h01);
    for (int i = 2; i <= 9; i++) rdchk(i[3:0], 8'h00);
    ird(PVI_I_EN_A, v);
    chk("enable a", v, 8'h00);
  endtask

  task automatic t_gpio();
    iwr(PVI_I_DIR, 8'h0f);
    u_pvi_host_model.wr(PVI_A_PORT, 8'ha5);
    chk("port latch", gpio_out, 8'ha5);
    chk("pin dir", gpio_oe_n, 8'hf0);
    pin_drv = 8'h3c;
    cyc(4);
    rdchk(PVI_A_PORT, 8'h35);
    ird(PVI_I_DIR, v);
    chk("dir read", v, 8'h0f);
    pin_drv = 8'hff;
    iwr(PVI_I_DIR, 8'h00);
  endtask

  task automatic t_pend();
    iwr(PVI_I_EDGE, 8'h00);
    iwr(PVI_I_EN_B, 8'hff);
    ev(0);
    rdchk(PVI_A_PEND_B, 8'h01);
    iwr(PVI_I_EDGE, 8'h02);
    rdchk(PVI_A_PEND_B, 8'h03);
    u_pvi_host_model.wr(PVI_A_PEND_B, 8'hfe);
    rdchk(PVI_A_PEND_B, 8'h02);
    iwr(PVI_I_EN_B, 8'hfd);
    rdchk(PVI_A_PEND_B, 8'h00);
    ev(1);
    rdchk(PVI_A_PEND_B, 8'h00);
    iwr(PVI_I_EDGE, 8'h00);
    ird(PVI_I_EN_B, v);
    chk("enable b", v, 8'hfd);
  endtask

  task automatic t_vec();
    pv_ctl = 8'ha0;
    u_pvi_host_model.wr(PVI_A_PV, pv_ctl);
    iwr(PVI_I_EN_A, 8'hff);
    iwr(PVI_I_EN_B, 8'hff);
    u_pvi_host_model.wr(PVI_A_MASK_A, 8'hff);
    u_pvi_host_model.wr(PVI_A_MASK_B, 8'hff);
    rdchk(PVI_A_MASK_A, 8'hff);
    for (int c = 0; c < 16; c++) begin
      ev(c);
      rdchk((c >= 8) ? PVI_A_PEND_A : PVI_A_PEND_B, 8'h01 << c[2:0]);
      chk("request", {7'h0, irq_oe_n}, 8'h00);
      ackchk(c[3:0]);
      chk("request", {7'h0, irq_oe_n}, 8'h01);
      chk("chain out", {7'h0, priority_out}, 8'h01);
    end
    rdchk(PVI_A_ISR_A, 8'h00);
  endtask

  task automatic t_prio();
    u_pvi_host_model.wr(PVI_A_MASK_A, 8'hfe);
    ev(8);
    ev(7);
    ackchk(4'h7);
    chk("request", {7'h0, irq_oe_n}, 8'h01);
    rdchk(PVI_A_PEND_A, 8'h01);
    u_pvi_host_model.wr(PVI_A_MASK_A, 8'hff);
    chk("request", {7'h0, irq_oe_n}, 8'h00);
    priority_in = 1'b0;
    cyc(6);
    chk("request", {7'h0, irq_oe_n}, 8'h01);
    chk("chain out", {7'h0, priority_out}, 8'h00);
    u_pvi_host_model.ack(oe, v);
    chk("ack drive", {7'h0, oe}, 8'h01);
    priority_in = 1'b1;
    cyc(6);
    ackchk(4'h8);
  endtask

  task automatic t_soft();
    pv_ctl = 8'ha8;
    u_pvi_host_model.wr(PVI_A_PV, pv_ctl);
    ev(8);
    ackchk(4'h8);
    rdchk(PVI_A_ISR_A, 8'h01);
    ev(5);
    chk("request", {7'h0, irq_oe_n}, 8'h01);
    ev(8);
    chk("request", {7'h0, irq_oe_n}, 8'h01);
    rdchk(PVI_A_PEND_A, 8'h01);
    ev(13);
    ackchk(4'hd);
    rdchk(PVI_A_ISR_A, 8'h21);
    u_pvi_host_model.irq_return();
    rdchk(PVI_A_ISR_A, 8'h01);
    u_pvi_host_model.wr(PVI_A_ISR_A, 8'hff);
    rdchk(PVI_A_ISR_A, 8'h01);
    u_pvi_host_model.wr(PVI_A_ISR_A, 8'hfe);
    rdchk(PVI_A_ISR_A, 8'h00);
    ackchk(4'h8);
    u_pvi_host_model.irq_return();
    ackchk(4'h5);
    iwr(PVI_I_EN_B, 8'h00);
    rdchk(PVI_A_ISR_B, 8'h20);
    u_pvi_host_model.wr(PVI_A_ISR_B, 8'h00);
    rdchk(PVI_A_ISR_B, 8'h00);
  endtask

  // reset in mid-run with a request, a pending bit and an output pin live
  task automatic t_rerst();
    iwr(PVI_I_DIR, 8'h01);
    ev(15);
    chk("request", {7'h0, irq_oe_n}, 8'h00);
    rst_in = 1'b1;
    cyc(3);
    rst_in = 1'b0;
    pv_ctl = 8'h00;
    cyc(4);
    t_reset();
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    priority_in = 1'b1;
    pin_drv = 8'hff;
    src = '0;
    pv_ctl = 8'h00;
    fail_count = 0;
    check_count = 0;
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    cyc(4);
    t_reset();
    t_gpio();
    t_pend();
    t_vec();
    t_prio();
    t_soft();
    t_rerst();
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk_in);
    fail_count++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
